/* File: rtl/pspc_pkg.sv */
// Package with codes, states, timing counts and the carrier struct for the PIPE status block.
package pspc_pkg;

  // Receive status codes reported with the received stream.
  localparam logic [2:0] PSPC_RXS_OK        = 3'h0;
  localparam logic [2:0] PSPC_RXS_SKP_ADD   = 3'h1;
  localparam logic [2:0] PSPC_RXS_SKP_DEL   = 3'h2;
  localparam logic [2:0] PSPC_RXS_RX_DET    = 3'h3;
  localparam logic [2:0] PSPC_RXS_DEC_ERR   = 3'h4;
  localparam logic [2:0] PSPC_RXS_EB_OVF    = 3'h5;
  localparam logic [2:0] PSPC_RXS_EB_UNF    = 3'h6;
  localparam logic [2:0] PSPC_RXS_DISP_ERR  = 3'h7;

  // Power-down field encodings.
  localparam logic [1:0] PSPC_PD_P0 = 2'h0;
  localparam logic [1:0] PSPC_PD_P1 = 2'h1;
  localparam logic [1:0] PSPC_PD_P2 = 2'h2;
  localparam logic [1:0] PSPC_PD_P3 = 2'h3;

  // Clock rate and settle times of the analog parts.
  localparam int unsigned PSPC_CLK_MHZ       = 100;
  localparam int unsigned PSPC_P1_EXIT_NS    = 100;
  localparam int unsigned PSPC_P2_EXIT_NS    = 1000;
  localparam int unsigned PSPC_DETECT_NS     = 500;
  localparam int unsigned PSPC_P1_EXIT_CYC   = (PSPC_P1_EXIT_NS * PSPC_CLK_MHZ + 999) / 1000;
  localparam int unsigned PSPC_P2_EXIT_CYC   = (PSPC_P2_EXIT_NS * PSPC_CLK_MHZ + 999) / 1000;
  localparam int unsigned PSPC_DETECT_CYC    = (PSPC_DETECT_NS * PSPC_CLK_MHZ + 999) / 1000;
  localparam int unsigned PSPC_CNT_W         = 8;

  // Power controller states.
  typedef enum logic [2:0] {
    PSPC_ST_ACTIVE  = 3'h0,
    PSPC_ST_SETTLE  = 3'h1,
    PSPC_ST_DETECT  = 3'h2,
    PSPC_ST_DONE    = 3'h3,
    PSPC_ST_RESET   = 3'h4
  } pspc_state_e;

  // Elastic buffer and decoder events from the receive path.
  typedef struct packed {
    logic skp_added;
    logic skp_removed;
    logic decode_err;
    logic eb_overflow;
    logic eb_underflow;
    logic disparity_err;
  } pspc_rx_evt_s;

endpackage

/* File: rtl/pspc_status_power.sv */
// PIPE receive status, power-state control and completion strobe logic.
`timescale 1ns/1ps
module pspc_status_power
  import pspc_pkg::*;
(
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         srst,
  // Controller-side requests (asynchronous to clk).
  input  wire logic         phy_reset_low,
  input  wire logic [1:0]   power_down,
  input  wire logic         rate_change,
  input  wire logic         detect_or_loopback_request,
  // Receive path events and configuration.
  input  wire pspc_rx_evt_s rx_evt,
  input  wire logic         eb_nominal_empty,
  input  wire logic         far_receiver_present,
  input  wire logic         vbus_sense,
  // Status outputs to the controller.
  output logic [2:0]        rx_status,
  output logic              operation_done_strobe,
  output logic [1:0]        power_state,
  output logic              phy_in_reset,
  output logic              bus_power_present
);

  // Two-stage synchronisers for every asynchronous input.
  logic [6:0] sync1_reg;                 // First stage, read only by the second.
  logic [6:0] sync2_reg;                 // Second stage, safe for logic.
  wire  [6:0] async_in = {vbus_sense, far_receiver_present, detect_or_loopback_request,
                          rate_change, power_down, phy_reset_low};

  // Synchroniser flops; they clear to all low, so the reset request reads as asserted
  // until the pin is really seen high and no false release follows srst.
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_reg <= 7'h00;
      sync2_reg <= 7'h00;
    end else begin
      sync1_reg <= async_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Named views of the synchronised inputs.
  wire       rst_low_s  = sync2_reg[0];
  wire [1:0] pd_s       = sync2_reg[2:1];
  wire       rate_s     = sync2_reg[3];
  wire       det_s      = sync2_reg[4];
  wire       rcv_s      = sync2_reg[5];
  wire       vbus_s     = sync2_reg[6];

  // Previous synchronised values for edge detection.
  logic [1:0] pd_prev_reg;               // Last accepted power-down request.
  logic       rate_prev_reg;             // Last rate-change level.
  logic       det_prev_reg;              // Last detect request level.
  logic [1:0] pd_hold_reg;               // Power-down sample one cycle older.

  // State machine and outputs.
  pspc_state_e          state_reg, state_next;
  logic [PSPC_CNT_W-1:0] cnt_reg, cnt_next;
  logic [1:0]           pstate_reg, pstate_next;
  logic                 done_reg, done_next;
  logic                 det_hit_reg, det_hit_next;
  logic [2:0]           rxs_reg;
  logic                 vbus_reg;

  // Request decode.
  // Power-down is a two-bit level; it is taken only when two successive synchronised
  // samples agree, so bits skewed across the crossing never decode an unasked state.
  wire pd_steady   = (pd_s == pd_hold_reg);
  wire pd_change   = (pd_s != pd_prev_reg) && pd_steady;
  wire rate_rise   = rate_s & ~rate_prev_reg;
  wire det_rise    = det_s & ~det_prev_reg;
  wire in_reset    = ~rst_low_s;
  // Settle time for the new state; P3 exit is handled without an interface clock count.
  wire [PSPC_CNT_W-1:0] settle_cnt =
    (pd_s == PSPC_PD_P2) ? PSPC_CNT_W'(PSPC_P2_EXIT_CYC)
                         : PSPC_CNT_W'(PSPC_P1_EXIT_CYC);

  // Next-state logic for power transitions, rate change and receiver detection.
  always_comb begin
    // Defaults: hold state and counter, no strobe.
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    pstate_next  = pstate_reg;
    done_next    = 1'b0;
    det_hit_next = det_hit_reg;
    case (state_reg)
      PSPC_ST_RESET: begin
        // Hold in reset until the controller releases the active-low reset.
        pstate_next = PSPC_PD_P0;
        if (!in_reset) begin
          state_next = PSPC_ST_DONE;
        end
      end
      PSPC_ST_ACTIVE: begin
        // Idle: take one request, power-down first, then rate, then detect.
        if (pd_change) begin
          // Power state change requested.
          pstate_next = pd_s;
          if (pd_s == PSPC_PD_P3 || pd_prev_reg == PSPC_PD_P3) begin
            // P3 entry/exit completes without counting on the interface clock.
            state_next = PSPC_ST_DONE;
          end else begin
            cnt_next   = settle_cnt;
            state_next = PSPC_ST_SETTLE;
          end
        end else if (rate_rise) begin
          // Rate change takes the short settle time.
          cnt_next   = PSPC_CNT_W'(PSPC_P1_EXIT_CYC);
          state_next = PSPC_ST_SETTLE;
        end else if (det_rise) begin
          // Receiver detection requested by the controller.
          cnt_next   = PSPC_CNT_W'(PSPC_DETECT_CYC);
          state_next = PSPC_ST_DETECT;
        end
      end
      PSPC_ST_SETTLE: begin
        // Wait for the analog parts to settle.
        if (cnt_reg <= PSPC_CNT_W'(1)) begin
          state_next = PSPC_ST_DONE;
        end else begin
          cnt_next = cnt_reg - PSPC_CNT_W'(1);
        end
      end
      PSPC_ST_DETECT: begin
        // Sample the far receiver at the end of the detect window.
        if (cnt_reg <= PSPC_CNT_W'(1)) begin
          det_hit_next = rcv_s;
          state_next   = PSPC_ST_DONE;
        end else begin
          cnt_next = cnt_reg - PSPC_CNT_W'(1);
        end
      end
      PSPC_ST_DONE: begin
        // One-cycle completion strobe.
        done_next  = 1'b1;
        state_next = PSPC_ST_ACTIVE;
      end
      default: begin
        state_next = PSPC_ST_RESET;
      end
    endcase
    // A reset request overrides whatever the machine was doing.
    if (in_reset) begin
      state_next = PSPC_ST_RESET;
    end
  end

  // Receive status priority: detect result, then errors, then SKP adjustments.
  wire [2:0] rxs_next =
    (done_next && det_hit_reg)                    ? PSPC_RXS_RX_DET   :
    rx_evt.decode_err                             ? PSPC_RXS_DEC_ERR  :
    rx_evt.disparity_err                          ? PSPC_RXS_DISP_ERR :
    rx_evt.eb_overflow                            ? PSPC_RXS_EB_OVF   :
    (rx_evt.eb_underflow && !eb_nominal_empty)    ? PSPC_RXS_EB_UNF   :
    rx_evt.skp_added                              ? PSPC_RXS_SKP_ADD  :
    rx_evt.skp_removed                            ? PSPC_RXS_SKP_DEL  :
                                                    PSPC_RXS_OK;

  // State registers.
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg   <= PSPC_ST_RESET;
      cnt_reg     <= '0;
      pstate_reg  <= PSPC_PD_P0;
      done_reg    <= 1'b0;
      det_hit_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      pstate_reg  <= pstate_next;
      done_reg    <= done_next;
      // The detect result is dropped once reported, so a later strobe cannot repeat it.
      det_hit_reg <= (state_reg == PSPC_ST_DONE) ? 1'b0 : det_hit_next;
    end
  end

  // Edge-detect history and status output registers.
  always_ff @(posedge clk) begin
    if (srst) begin
      pd_prev_reg   <= PSPC_PD_P0;
      pd_hold_reg   <= PSPC_PD_P0;
      rate_prev_reg <= 1'b0;
      det_prev_reg  <= 1'b0;
      rxs_reg       <= PSPC_RXS_OK;
      vbus_reg      <= 1'b0;
    end else begin
      // Edge history other than pd_hold_reg moves only while idle, so an edge seen during a transition is taken after it.
      pd_prev_reg   <= (state_reg == PSPC_ST_ACTIVE && pd_steady) ? pd_s : pd_prev_reg;
      pd_hold_reg   <= pd_s;
      rate_prev_reg <= (state_reg == PSPC_ST_ACTIVE) ? rate_s : rate_prev_reg;
      det_prev_reg  <= (state_reg == PSPC_ST_ACTIVE) ? det_s : det_prev_reg;
      rxs_reg       <= in_reset ? PSPC_RXS_OK : rxs_next;
      // Bus power shows three clocks after the pin: two sync stages and this flop.
      vbus_reg      <= vbus_s;
    end
  end

  // Outputs; the strobe is a clean flop so the controller can capture it asynchronously.
  assign rx_status             = rxs_reg;
  assign operation_done_strobe = done_reg;
  assign power_state           = pstate_reg;
  // The reset flag is a decode of the state register, so it follows the machine exactly.
  assign phy_in_reset          = (state_reg == PSPC_ST_RESET);
  assign bus_power_present     = vbus_reg;

endmodule

/* File: test/pspc_status_power_monitor.sv */
// Port checks for the PIPE status and power block.
`timescale 1ns/1ps
module pspc_status_power_monitor
  import pspc_pkg::*;
(
  // Clock and resets.
  input wire logic         clk,
  input wire logic         srst,
  input wire logic         phy_reset_low,
  // Watched inputs.
  input wire pspc_rx_evt_s rx_evt,
  input wire logic         eb_nominal_empty,
  input wire logic         vbus_sense,
  // Watched outputs.
  input wire logic [2:0]   rx_status,
  input wire logic         operation_done_strobe,
  input wire logic [1:0]   power_state,
  input wire logic         phy_in_reset,
  input wire logic         bus_power_present
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // A detect result or reset may take the place of an event code.
  wire stb = operation_done_strobe;
  wire ovr = stb | phy_in_reset;
  chk_skp_added: assert property (
    rx_evt == 6'h20 |=> ovr || rx_status == 3'h1) else $error("bad insert code");
  chk_skp_removed: assert property (
    rx_evt == 6'h10 |=> ovr || rx_status == 3'h2) else $error("bad delete code");
  chk_unf_hidden: assert property (
    rx_evt == 6'h02 && eb_nominal_empty |=> ovr || rx_status == 3'h0) else $error("underflow shown");
  chk_strobe_pulse: assert property (
    $rose(stb) |=> !stb) else $error("strobe too long");
  chk_p1_settle: assert property (
    $changed(power_state) && power_state == 2'h1 |-> ##[10:12] stb) else $error("P1 timing");
  chk_p2_settle: assert property (
    $changed(power_state) && power_state == 2'h2 |-> ##[100:102] stb) else $error("P2 timing");
  chk_bus_power: assert property (
    $stable(vbus_sense)[*4] |=> bus_power_present == $past(vbus_sense)) else $error("bus power");
  chk_reset_hold: assert property (
    !phy_reset_low[*4] |-> phy_in_reset && rx_status == 3'h0) else $error("reset not held");
endmodule

/* File: test/pspc_mac_model.sv */
// Link controller model: drives requests and times the completion strobe.
`timescale 1ns/1ps
module pspc_mac_model (
  // Clock and strobe from the device.
  input  wire logic  clk,
  input  wire logic  operation_done_strobe,
  // Requests to the device.
  output logic       phy_reset_low,
  output logic [1:0] power_down,
  output logic       rate_change,
  output logic       detect_or_loopback_request
);
  // Device held in reset, no request pending, at time zero.
  initial {phy_reset_low, power_down, rate_change, detect_or_loopback_request} = '0;
  // Kind 0 power, 1 rate, 2 detect, 3 reset level; returns cycles to the strobe.
  task automatic request(input logic [1:0] kind, input logic [1:0] pd, output int cyc);
    cyc = 0;
    @(negedge clk);
    if (kind == 2'h0) power_down = pd;
    if (kind == 2'h1) rate_change = 1'b1;
    if (kind == 2'h2) detect_or_loopback_request = 1'b1;
    if (kind == 2'h3) phy_reset_low = pd[0];
    // Strobe polled as a level; entering reset gives none, so no wait.
    while (operation_done_strobe !== 1'b1 && cyc < 400 && (kind != 2'h3 || pd[0])) begin
      @(negedge clk);
      cyc++;
    end
    {rate_change, detect_or_loopback_request} = 2'h0;
  endtask
endmodule

/* File: test/tb_pspc_status_power.sv */
// Directed bench for the PIPE status and power block.
`timescale 1ns/1ps
module tb_pspc_status_power;
  import pspc_pkg::*;
  logic clk = 1'b0, srst = 1'b1, phy_reset_low, rate_change, detect_or_loopback_request;
  logic [1:0] power_down, power_state;
  pspc_rx_evt_s rx_evt = '0;
  logic eb_nominal_empty = 1'b0, far_receiver_present = 1'b1, vbus_sense = 1'b1;
  logic [2:0] rx_status;
  logic operation_done_strobe, phy_in_reset, bus_power_present;
  int num_errors = 0, checks_done = 0, cyc;
  // Event sets with codes, power requests with latencies.
  logic [5:0] ev[8] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h02, 6'h01, 6'h09};
  logic [2:0] code[8] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h0, 3'h7, 3'h4};
  logic [1:0] pd[6] = '{2'h1, 2'h0, 2'h2, 2'h0, 2'h3, 2'h0};
  // Power latency: two sync stages, one agreement cycle, the settle count, DONE, the flop.
  int lat[6] = '{PSPC_P1_EXIT_CYC + 5, 0, PSPC_P2_EXIT_CYC + 5, 0, 5, 5};
  always #5 clk = ~clk;
  pspc_status_power u_pspc_status_power (
    .clk                        (clk),
    .srst                       (srst),
    .phy_reset_low              (phy_reset_low),
    .power_down                 (power_down),
    .rate_change                (rate_change),
    .detect_or_loopback_request (detect_or_loopback_request),
    .rx_evt                     (rx_evt),
    .eb_nominal_empty           (eb_nominal_empty),
    .far_receiver_present       (far_receiver_present),
    .vbus_sense                 (vbus_sense),
    .rx_status                  (rx_status),
    .operation_done_strobe      (operation_done_strobe),
    .power_state                (power_state),
    .phy_in_reset               (phy_in_reset),
    .bus_power_present          (bus_power_present)
  );
  pspc_mac_model u_pspc_mac_model (
    .clk                        (clk),
    .operation_done_strobe      (operation_done_strobe),
    .phy_reset_low              (phy_reset_low),
    .power_down                 (power_down),
    .rate_change                (rate_change),
    .detect_or_loopback_request (detect_or_loopback_request)
  );
  // Compares a status value.
  task automatic check(input logic [2:0] got, input logic [2:0] exp);
    checks_done++;
    if (got !== exp) num_errors++;
    if (got !== exp) $display("mismatch at %0t: got %h want %h", $time, got, exp);
  endtask
  // Compares a latency within two cycles; zero asks only for a strobe.
  task automatic check_lat(input int exp);
    checks_done++;
    if (cyc >= 400 || (exp > 0 && (cyc < exp - 2 || cyc > exp + 2))) begin
      num_errors++;
      $display("mismatch at %0t: latency %0d want %0d", $time, cyc, exp);
      if (cyc >= 400) close_out();
    end
  endtask
  // Prints counts and verdict, then stops.
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    srst = 1'b0;
    u_pspc_mac_model.request(2'h3, 2'h1, cyc);
    check_lat(4);
    check(3'(bus_power_present), 3'h1);
    foreach (pd[i]) begin
      u_pspc_mac_model.request(2'h0, pd[i], cyc);
      check_lat(lat[i]);
      check(3'(power_state), 3'(pd[i]));
    end
    $display("test power states done");
    for (int k = 0; k < 3; k++) begin
      far_receiver_present = (k == 1);
      u_pspc_mac_model.request(k == 0 ? 2'h1 : 2'h2, 2'h0, cyc);
      check_lat(k == 0 ? PSPC_P1_EXIT_CYC + 4 : PSPC_DETECT_CYC + 4);
      if (k > 0) check(rx_status, k == 1 ? PSPC_RXS_RX_DET : PSPC_RXS_OK);
    end
    $display("test rate and detect done");
    foreach (ev[i]) begin
      eb_nominal_empty = (i == 5);
      rx_evt = ev[i];
      @(negedge clk);
      rx_evt = '0;
      check(rx_status, code[i]);
    end
    vbus_sense = 1'b0;
    u_pspc_mac_model.request(2'h3, 2'h0, cyc);
    rx_evt = 6'h08;
    repeat (5) @(negedge clk);
    check(rx_status, PSPC_RXS_OK);
    check(3'(phy_in_reset), 3'h1);
    check(3'(bus_power_present), 3'h0);
    rx_evt = '0;
    u_pspc_mac_model.request(2'h3, 2'h1, cyc);
    check_lat(4);
    $display("test events and reset done");
    close_out();
  end
endmodule
bind pspc_status_power pspc_status_power_monitor u_pspc_status_power_monitor (
  .clk                   (clk),
  .srst                  (srst),
  .phy_reset_low         (phy_reset_low),
  .rx_evt                (rx_evt),
  .eb_nominal_empty      (eb_nominal_empty),
  .vbus_sense            (vbus_sense),
  .rx_status             (rx_status),
  .operation_done_strobe (operation_done_strobe),
  .power_state           (power_state),
  .phy_in_reset          (phy_in_reset),
  .bus_power_present     (bus_power_present)
);
